// [design/mpc_pkg.sv]
// Constants for the multifunction pin control block
package mpc_pkg;
    localparam logic [7:0] CFG_OFFSET = 8'h24;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam int FILT_EN_BIT = 15;
    localparam int SLEEP_EN_BIT = 14;
    localparam int OUT_EN_BIT = 13;
    localparam int OSEL_LSB = 9;
    localparam int MASK_LSB = 5;
    localparam int IFUNC_LSB = 1;
    localparam int IN_EN_BIT = 0;
    localparam int NUM_CH = 4;
    localparam int FILT_LEN = 4;
    localparam logic [3:0] OSEL_MEM_BUSY = 4'h1;
    localparam logic [3:0] OSEL_CH0_BUSY = 4'h4;
    localparam logic [3:0] OSEL_CH1_BUSY = 4'h5;
    localparam logic [3:0] OSEL_CH2_BUSY = 4'h6;
    localparam logic [3:0] OSEL_CH3_BUSY = 4'h7;
    localparam logic [3:0] OSEL_WIN0 = 4'h8;
    localparam logic [3:0] OSEL_WIN1 = 4'h9;
    localparam logic [3:0] OSEL_WIN2 = 4'ha;
    localparam logic [3:0] OSEL_WIN3 = 4'hb;
    localparam logic [3:0] IF_SLEEP = 4'h0;
    localparam logic [3:0] IF_FAULT_DUMP = 4'h2;
    localparam logic [3:0] IF_CURRENT_OUTPUT_PWR = 4'h3;
    localparam logic [3:0] IF_VOLTAGE_OUTPUT_PWR = 4'h4;
    localparam logic [3:0] IF_PROTECT = 4'h5;
    localparam logic [3:0] IF_CLEAR = 4'h7;
    localparam logic [3:0] IF_LOAD = 4'h8;
    localparam logic [3:0] IF_WAVE = 4'h9;
    localparam logic [3:0] IF_MARGIN = 4'ha;
    localparam logic [3:0] IF_RESET = 4'hb;
    localparam logic [3:0] IF_NVM_WP = 4'hc;
    localparam logic [3:0] IF_MAP_LOCK = 4'hd;
    localparam logic [1:0] PROT_HIZ = 2'h0;
endpackage

// [design/mpc_sync.sv]
// Two-stage synchroniser with edge detection for the pin input
`timescale 1ns/1ps
module mpc_sync (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic din,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta, next_meta;
    logic sync, next_sync;
    logic prev, next_prev;

    always_comb begin
        next_meta = din;
        next_sync = meta;
        next_prev = sync;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta <= 1'b1;
            sync <= 1'b1;
            prev <= 1'b1;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            prev <= next_prev;
        end
    end

    assign level = sync;
    assign rise = sync & ~prev;
    assign fall = ~sync & prev;
endmodule

// [design/mpc_filter.sv]
// Optional glitch filter: level must hold for LEN cycles to pass
`timescale 1ns/1ps
module mpc_filter #(
    parameter int LEN = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic din,
    output logic dout
);
    logic [$clog2(LEN+1)-1:0] cnt, next_cnt;
    logic held, next_held;

    always_comb begin
        next_cnt = '0;
        next_held = held;
        if (din != held) begin
            next_cnt = cnt + 1'b1;
            if (cnt == ($clog2(LEN+1))'(LEN - 1)) begin
                next_held = din;
                next_cnt = '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt <= '0;
            held <= 1'b1;
        end else begin
            cnt <= next_cnt;
            held <= next_held;
        end
    end

    // Bypass gives the faster response
    assign dout = enable ? held : din;
endmodule

// [design/mpc_top.sv]
// Multifunction pin configuration register, input actions and status output
`timescale 1ns/1ps
// Notes on behaviour
// [RQ1] Bit 15 inserts glitch filter on input
// [RQ2] Bit 14 permits sleep entry from pin
// [RQ3] Bit 13 enables pin output driver
// [RQ4] Bits 12-9 select routed status bit
// [RQ5] Codes 4-7 channel busy; 8-b window results
// [RQ6] Bits 8-5 mask channels for actions
// [RQ7] Bits 4-1 pick pin input action
// [RQ8] Function 0: fall sleeps, rise wakes
// [RQ9] Function 2: fall triggers fault dump
// [RQ10] Function 3: current outputs down/up by edge
// [RQ11] Function 4: voltage outputs down/up by edge
// [RQ12] Function 5: fall starts protect sequence
// [RQ13] Function 7: low level asserts output clear
// [RQ14] Function 8: fall loads pending channel data
// [RQ15] Function 9: rise starts, fall stops waveform
// [RQ16] Function 10: fall margin-low, rise margin-high
// [RQ17] Function 11: fall holds reset, rise releases
// [RQ18] Reset function survives reset only if stored
// [RQ19] Function 12: fall allows, rise blocks programming
// [RQ20] Function 13: rise locks map, fall unlocks
// [RQ21] Other function codes ignore the pin
// [RQ22] Bit 0 enables input actions
// [RQ23] Input synchronised, one action per edge
// [RQ24] Channel busy bit mirrored when selected
// [RQ25] Protect mode 00 goes straight hi-z
module mpc_top
    import mpc_pkg::*;
#(
    parameter int CHANNELS = mpc_pkg::NUM_CH,
    parameter int FILTER_LEN = mpc_pkg::FILT_LEN
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic nvm_reset_stored,
    input wire logic [1:0] protect_mode,
    input wire logic memory_program_busy,
    input wire logic [3:0] channel_busy,
    input wire logic [3:0] channel_window_result,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic sleep_active,
    output logic fault_dump,
    output logic protect_start,
    output logic protect_hiz,
    output logic output_clear,
    output logic device_reset_hold,
    output logic nvm_program_allow,
    output logic map_locked,
    output logic [3:0] current_output_down,
    output logic [3:0] voltage_output_down,
    output logic [3:0] load_outputs,
    output logic [3:0] wave_run,
    output logic [3:0] margin_low,
    output logic [3:0] margin_high
);
    import mpc_pkg::*;

    logic [15:0] cfg, next_cfg;
    logic s_level, s_rise, s_fall, f_level, f_prev, next_f_prev, p_rise, p_fall;
    logic [3:0] ifunc, mask, osel;
    logic in_en, out_en, sleep_en, filt_en;
    logic cfg_wr, keep_cfg;

    assign ifunc = cfg[IFUNC_LSB +: 4];
    assign mask = cfg[MASK_LSB +: 4];
    assign osel = cfg[OSEL_LSB +: 4];
    assign in_en = cfg[IN_EN_BIT];
    assign out_en = cfg[OUT_EN_BIT];
    assign sleep_en = cfg[SLEEP_EN_BIT];
    assign filt_en = cfg[FILT_EN_BIT];
    // Writes refused while the map is locked
    assign cfg_wr = reg_wr && reg_addr == CFG_OFFSET && !map_locked;
    // Stored pin reset setting outlives a device reset
    assign keep_cfg = nvm_reset_stored && ifunc == IF_RESET;

    mpc_sync u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(pin_in),
        .level(s_level),
        .rise(),
        .fall()
    );

    mpc_filter #(.LEN(FILTER_LEN)) u_filter (
        .clk(clk),
        .sys_rst(sys_rst),
        .enable(filt_en), // see [RQ1]
        .din(s_level),
        .dout(f_level)
    );

    // Edges taken after the filter, one pulse each
    assign p_rise = f_level & ~f_prev; // see [RQ23]
    assign p_fall = ~f_level & f_prev; // see [RQ23]
    assign s_rise = p_rise & in_en; // see [RQ22]
    assign s_fall = p_fall & in_en; // see [RQ22]

    // Configuration register
    always_comb begin
        next_cfg = cfg;
        next_f_prev = f_level;
        if (cfg_wr) begin
            next_cfg = reg_wdata;
        end
        // Reset function kept only when held in memory
        if (sys_rst && keep_cfg) begin
            next_cfg = cfg; // see [RQ18]
        end
    end

    // Post-filter level one cycle back
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            f_prev <= 1'b1;
        end else begin
            f_prev <= next_f_prev;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst && !keep_cfg) begin
            cfg <= CFG_RESET; // see [RQ18]
        end else begin
            cfg <= next_cfg;
        end
    end

    // Status output
    logic next_pin_out, next_pin_oe;
    logic [15:0] next_rdata;
    always_comb begin
        next_pin_oe = out_en; // see [RQ3]
        next_rdata = 16'h0000;
        if (reg_addr == CFG_OFFSET) begin
            next_rdata = cfg;
        end
        // Invalid codes park the pin low
        unique case (osel) // see [RQ4]
            OSEL_MEM_BUSY: next_pin_out = memory_program_busy;
            OSEL_CH0_BUSY: next_pin_out = channel_busy[0]; // see [RQ24]
            OSEL_CH1_BUSY: next_pin_out = channel_busy[1];
            OSEL_CH2_BUSY: next_pin_out = channel_busy[2]; // see [RQ5]
            OSEL_CH3_BUSY: next_pin_out = channel_busy[3];
            OSEL_WIN0: next_pin_out = channel_window_result[0];
            OSEL_WIN1: next_pin_out = channel_window_result[1];
            OSEL_WIN2: next_pin_out = channel_window_result[2];
            OSEL_WIN3: next_pin_out = channel_window_result[3];
            default: next_pin_out = 1'b0;
        endcase
        if (!out_en) begin
            next_pin_out = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            reg_rdata <= 16'h0000;
        end else begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            reg_rdata <= next_rdata;
        end
    end

    // Global actions
    logic next_sleep, next_dump, next_prot, next_hiz, next_clear;
    logic next_rst_hold, next_nvm_allow, next_lock;
    always_comb begin
        next_sleep = sleep_active;
        // Pulses last a single cycle
        next_dump = 1'b0;
        next_prot = 1'b0;
        next_hiz = protect_hiz;
        next_clear = 1'b0;
        next_rst_hold = device_reset_hold;
        next_nvm_allow = nvm_program_allow;
        next_lock = map_locked;
        unique case (ifunc) // see [RQ7]
            IF_SLEEP: begin
                if (s_fall && sleep_en) next_sleep = 1'b1; // see [RQ8] [RQ2]
                if (s_rise) next_sleep = 1'b0; // see [RQ8]
            end
            IF_FAULT_DUMP: next_dump = s_fall; // see [RQ9]
            IF_PROTECT: begin
                next_prot = s_fall; // see [RQ12]
                if (s_fall && protect_mode == PROT_HIZ) next_hiz = 1'b1; // see [RQ25]
            end
            IF_CLEAR: next_clear = in_en & ~f_level; // see [RQ13]
            IF_RESET: begin
                if (s_fall) next_rst_hold = 1'b1; // see [RQ17]
                if (s_rise) next_rst_hold = 1'b0;
            end
            IF_NVM_WP: begin
                if (s_fall) next_nvm_allow = 1'b1; // see [RQ19]
                if (s_rise) next_nvm_allow = 1'b0;
            end
            IF_MAP_LOCK: begin
                if (s_fall) next_lock = 1'b0; // see [RQ20]
                if (s_rise) next_lock = 1'b1;
            end
            default: ; // see [RQ21]
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sleep_active <= 1'b0;
            fault_dump <= 1'b0;
            protect_start <= 1'b0;
            protect_hiz <= 1'b0;
            output_clear <= 1'b0;
            device_reset_hold <= 1'b0;
            nvm_program_allow <= 1'b0;
            map_locked <= 1'b0;
        end else begin
            sleep_active <= next_sleep;
            fault_dump <= next_dump;
            protect_start <= next_prot;
            protect_hiz <= next_hiz;
            output_clear <= next_clear;
            device_reset_hold <= next_rst_hold;
            nvm_program_allow <= next_nvm_allow;
            map_locked <= next_lock;
        end
    end

    // Channel actions, gated per channel by the mask
    logic [3:0] next_current_output, next_voltage_output, next_load, next_wave, next_mlo, next_mhi;
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
            logic sel;
            assign sel = mask[ch]; // see [RQ6]
            always_comb begin
                // Levels hold until the opposite edge
                next_current_output[ch] = current_output_down[ch];
                next_voltage_output[ch] = voltage_output_down[ch];
                next_load[ch] = 1'b0;
                next_wave[ch] = wave_run[ch];
                next_mlo[ch] = margin_low[ch];
                next_mhi[ch] = margin_high[ch];
                if (sel) begin
                    unique case (ifunc)
                        IF_CURRENT_OUTPUT_PWR: begin
                            if (s_fall) next_current_output[ch] = 1'b1; // see [RQ10]
                            if (s_rise) next_current_output[ch] = 1'b0;
                        end
                        IF_VOLTAGE_OUTPUT_PWR: begin
                            if (s_fall) next_voltage_output[ch] = 1'b1; // see [RQ11]
                            if (s_rise) next_voltage_output[ch] = 1'b0;
                        end
                        IF_LOAD: next_load[ch] = s_fall; // see [RQ14]
                        IF_WAVE: begin
                            if (s_rise) next_wave[ch] = 1'b1; // see [RQ15]
                            if (s_fall) next_wave[ch] = 1'b0;
                        end
                        IF_MARGIN: begin
                            if (s_fall) begin
                                next_mlo[ch] = 1'b1; // see [RQ16]
                                next_mhi[ch] = 1'b0;
                            end
                            if (s_rise) begin
                                next_mlo[ch] = 1'b0;
                                next_mhi[ch] = 1'b1;
                            end
                        end
                        default: ;
                    endcase
                end
            end

            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    current_output_down[ch] <= 1'b0;
                    voltage_output_down[ch] <= 1'b0;
                    load_outputs[ch] <= 1'b0;
                    wave_run[ch] <= 1'b0;
                    margin_low[ch] <= 1'b0;
                    margin_high[ch] <= 1'b0;
                end else begin
                    current_output_down[ch] <= next_current_output[ch];
                    voltage_output_down[ch] <= next_voltage_output[ch];
                    load_outputs[ch] <= next_load[ch];
                    wave_run[ch] <= next_wave[ch];
                    margin_low[ch] <= next_mlo[ch];
                    margin_high[ch] <= next_mhi[ch];
                end
            end
        end
    endgenerate
endmodule

// [bench/mpc_assertions.sv]
// Port-level checker for the multifunction pin control block
`timescale 1ns/1ps
module mpc_assertions
    import mpc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic [1:0] protect_mode,
    input wire logic pin_oe,
    input wire logic fault_dump,
    input wire logic protect_start,
    input wire logic protect_hiz,
    input wire logic map_locked,
    input wire logic [3:0] load_outputs,
    input wire logic [3:0] wave_run,
    input wire logic [3:0] margin_low,
    input wire logic [3:0] margin_high
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_oe_from_cfg: assert property (reg_wr && reg_addr == CFG_OFFSET && !map_locked
        && reg_wdata[OUT_EN_BIT] |-> ##[1:2] pin_oe) else $error("pin_oe not set");
    a_dump_one_cycle: assert property (fault_dump |=> !fault_dump)
        else $error("fault_dump too long");
    a_prot_one_cycle: assert property (protect_start |=> !protect_start)
        else $error("protect_start too long");
    a_load_one_cycle: assert property (load_outputs != 4'h0 |=> load_outputs == 4'h0)
        else $error("load_outputs too long");
    a_margin_exclusive: assert property ((margin_low & margin_high) == 4'h0)
        else $error("margin low and high together");
    a_rdata_unmapped: assert property ($past(reg_addr) != CFG_OFFSET |-> reg_rdata == 16'h0000)
        else $error("read data at unmapped address");
    a_protect_hiz: assert property (protect_start && protect_mode == PROT_HIZ
        |-> ##[0:1] protect_hiz) else $error("protect_hiz missing");
    a_locked_write: assert property (map_locked && reg_wr && reg_addr == CFG_OFFSET
        |=> ##1 $stable(pin_oe)) else $error("write taken while locked");
    a_reset_clear: assert property ($fell(sys_rst) |-> !pin_oe && !map_locked && wave_run == 4'h0)
        else $error("outputs not cleared by reset");
    c_dump: cover property (fault_dump);
    c_lock: cover property ($rose(map_locked));
    c_load: cover property (load_outputs != 4'h0);
endmodule
bind mpc_top mpc_assertions chk_u (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .protect_mode(protect_mode), .pin_oe(pin_oe), .fault_dump(fault_dump),
    .protect_start(protect_start), .protect_hiz(protect_hiz), .map_locked(map_locked),
    .load_outputs(load_outputs), .wave_run(wave_run), .margin_low(margin_low),
    .margin_high(margin_high));

// [bench/mpc_pin_model.sv]
// Behavioural model of the external logic on the multifunction pin
`timescale 1ns/1ps
module mpc_pin_model (
    input wire logic clk,
    input wire logic req,
    input wire logic pin_oe,
    input wire logic pin_out,
    output logic pin_in
);
    logic drv = 1'b1;
    // Far side moves its level only at falling edges
    always @(negedge clk) begin
        drv <= req;
    end
    // Device owns the wire while it drives
    assign pin_in = pin_oe ? pin_out : drv;
endmodule

// [bench/tb_top.sv]
// Self-checking testbench for the multifunction pin control block
`timescale 1ns/1ps
module tb_top;
    import mpc_pkg::*;
    localparam int FLEN = 4;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic nvm_reset_stored = 1'b0;
    logic [1:0] protect_mode = 2'h0;
    logic memory_program_busy = 1'b0;
    logic [3:0] channel_busy = 4'h0;
    logic [3:0] channel_window_result = 4'h0;
    logic req = 1'b1;
    logic [15:0] reg_rdata;
    logic pin_in, pin_out, pin_oe, sleep_active, fault_dump, protect_start, protect_hiz;
    logic output_clear, device_reset_hold, nvm_program_allow, map_locked;
    logic [3:0] current_output_down, voltage_output_down, load_outputs, wave_run;
    logic [3:0] margin_low, margin_high;
    logic [3:0] load_seen = 4'h0;
    int num_errors = 0;
    int checks_done = 0;
    int n_dump = 0;
    int n_prot = 0;
    int n_load = 0;
    always #25 clk = ~clk;
    mpc_top #(.FILTER_LEN(FLEN)) dut_u (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .nvm_reset_stored(nvm_reset_stored), .protect_mode(protect_mode),
        .memory_program_busy(memory_program_busy), .channel_busy(channel_busy),
        .channel_window_result(channel_window_result), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .sleep_active(sleep_active), .fault_dump(fault_dump),
        .protect_start(protect_start), .protect_hiz(protect_hiz),
        .output_clear(output_clear), .device_reset_hold(device_reset_hold),
        .nvm_program_allow(nvm_program_allow), .map_locked(map_locked),
        .current_output_down(current_output_down), .voltage_output_down(voltage_output_down),
        .load_outputs(load_outputs), .wave_run(wave_run), .margin_low(margin_low),
        .margin_high(margin_high));
    mpc_pin_model pm_u (.clk(clk), .req(req), .pin_oe(pin_oe), .pin_out(pin_out),
        .pin_in(pin_in));
    // Pulse counters, one look per cycle
    always @(negedge clk) begin
        if (fault_dump === 1'b1) n_dump++;
        if (protect_start === 1'b1) n_prot++;
        if (load_outputs !== 4'h0) begin
            n_load++;
            load_seen = load_seen | load_outputs;
        end
    end
    function automatic logic [15:0] ic(input logic [3:0] m, input logic [3:0] f);
        return {7'h00, m, f, 1'b1};
    endfunction
    function automatic logic [3:0] get(input int s);
        case (s)
            0: return current_output_down;
            1: return voltage_output_down;
            2: return wave_run;
            3: return margin_low;
            4: return margin_high;
            5: return {3'h0, sleep_active};
            6: return {3'h0, output_clear};
            7: return {3'h0, device_reset_hold};
            8: return {3'h0, nvm_program_allow};
            default: return {3'h0, map_locked};
        endcase
    endfunction
    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rst(input int n);
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (n) @(negedge clk);
        sys_rst = 1'b0;
    endtask
    task automatic wr(input logic [15:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = CFG_OFFSET;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        chk(exp, reg_rdata);
    endtask
    // Pin edge, then wait out sync, filter and output latency
    task automatic pin(input logic v, input int len);
        @(posedge clk);
        req <= v;
        if (len > 0) begin
            repeat (len) @(posedge clk);
            req <= ~v;
        end
        repeat (FLEN + 10) @(negedge clk);
    endtask
    task automatic fr(input logic [15:0] c, input int s, input logic [3:0] ef,
        input logic [3:0] er);
        wr(c);
        pin(1'b0, 0);
        chk({12'h0, ef}, {12'h0, get(s)});
        pin(1'b1, 0);
        chk({12'h0, er}, {12'h0, get(s)});
    endtask
    task automatic t_regs();
        rd(CFG_OFFSET, CFG_RESET);
        rd(8'h25, 16'h0000);
        wr(16'h5a5a);
        rd(CFG_OFFSET, 16'h5a5a);
        wr(16'h0000);
    endtask
    task automatic t_out();
        logic [3:0] codes [9] = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb};
        for (int k = 0; k < 9; k++) begin
            wr(16'h2000 | (16'(codes[k]) << OSEL_LSB));
            for (int v = 0; v < 2; v++) begin
                {channel_window_result, channel_busy, memory_program_busy} =
                    (v == 1) ? (9'h001 << k) : ~(9'h001 << k);
                repeat (3) @(negedge clk);
                chk(16'(v), {15'h0, pin_out});
            end
        end
        wr(16'h2400);
        repeat (3) @(negedge clk);
        chk(16'h0000, {15'h0, pin_out});
        wr(16'h0200);
        repeat (3) @(negedge clk);
        chk(16'h0000, {14'h0, pin_oe, pin_out});
    endtask
    task automatic t_global();
        fr(ic(4'h0, IF_SLEEP) | 16'h4000, 5, 4'h1, 4'h0);
        fr(ic(4'h0, IF_SLEEP), 5, 4'h0, 4'h0);
        fr(ic(4'h0, IF_CLEAR), 6, 4'h1, 4'h0);
        fr(ic(4'h0, IF_RESET), 7, 4'h1, 4'h0);
        fr(ic(4'h0, IF_NVM_WP), 8, 4'h1, 4'h0);
        n_dump = 0;
        fr(ic(4'h0, IF_FAULT_DUMP), 9, 4'h0, 4'h0);
        chk(16'h0001, 16'(n_dump));
        fr(ic(4'h0, IF_PROTECT), 9, 4'h0, 4'h0);
        chk(16'h0001, 16'(n_prot));
        chk(16'h0001, {15'h0, protect_hiz});
        fr(ic(4'h0, IF_FAULT_DUMP) & 16'hfffe, 5, 4'h0, 4'h0);
        chk(16'h0001, 16'(n_dump));
        fr(ic(4'h0, 4'h1), 7, 4'h0, 4'h0);
        chk(16'h0001, 16'(n_dump));
        wr(ic(4'h0, IF_FAULT_DUMP) | 16'h8000);
        pin(1'b0, 2);
        chk(16'h0001, 16'(n_dump));
        pin(1'b0, 8);
        chk(16'h0002, 16'(n_dump));
        wr(ic(4'h0, IF_FAULT_DUMP));
        pin(1'b0, 2);
        chk(16'h0003, 16'(n_dump));
    endtask
    task automatic t_chan();
        fr(ic(4'h5, IF_CURRENT_OUTPUT_PWR), 0, 4'h5, 4'h0);
        fr(ic(4'ha, IF_VOLTAGE_OUTPUT_PWR), 1, 4'ha, 4'h0);
        fr(ic(4'h3, IF_WAVE), 2, 4'h0, 4'h3);
        fr(ic(4'hc, IF_MARGIN), 3, 4'hc, 4'h0);
        chk(16'h000c, {12'h0, margin_high});
        load_seen = 4'h0;
        fr(ic(4'h9, IF_LOAD), 1, 4'h0, 4'h0);
        chk(16'h0009, {12'h0, load_seen});
        chk(16'h0001, 16'(n_load));
    endtask
    task automatic t_lock();
        wr(ic(4'h0, IF_MAP_LOCK));
        pin(1'b0, 0);
        pin(1'b1, 0);
        chk(16'h0001, {15'h0, map_locked});
        wr(16'h2000);
        rd(CFG_OFFSET, ic(4'h0, IF_MAP_LOCK));
        pin(1'b0, 0);
        chk(16'h0000, {15'h0, map_locked});
        wr(16'h0000);
        pin(1'b1, 0);
        rd(CFG_OFFSET, 16'h0000);
    endtask
    task automatic t_rst();
        wr(ic(4'h0, IF_RESET));
        nvm_reset_stored = 1'b1;
        rst(2);
        rd(CFG_OFFSET, ic(4'h0, IF_RESET));
        nvm_reset_stored = 1'b0;
        rst(2);
        rd(CFG_OFFSET, 16'h0000);
        protect_mode = 2'h1;
        fr(ic(4'h0, IF_PROTECT), 9, 4'h0, 4'h0);
        chk(16'h0002, 16'(n_prot));
        chk(16'h0000, {15'h0, protect_hiz});
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        end_sim();
    end
    initial begin
        rst(20);
        t_regs();
        t_out();
        t_global();
        t_chan();
        t_lock();
        t_rst();
        end_sim();
    end
endmodule
